// [i2c_slave_model.sv]
// Behavioural two-wire slave that logs every byte written to it.
// Assumes both lines have pull-ups and are fed back as wire levels.
`timescale 1ns/1ns
module i2c_slave_model
(
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [7:0] i_nack_at,
    input wire logic i_stretch,
    output logic o_sda_oe,
    output logic o_scl_oe
);
    logic [7:0] rx_q[$];
    logic [7:0] sh = 8'h00;
    int nbits = 0;
    int starts = 0;
    int stops = 0;
    time last_rise = 0;
    time period = 0;

    initial
    begin
        o_sda_oe = 1'b0;
        o_scl_oe = 1'b0;
    end

    always @(negedge i_sda)
        if (i_scl === 1'b1)
        begin
            starts++;
            nbits = 0;
        end

    always @(posedge i_sda)
        if (i_scl === 1'b1)
        begin
            stops++;
            nbits = 0;
        end

    // Bits are taken on the rising clock edge, most significant first.
    always @(posedge i_scl)
    begin
        period = $time - last_rise;
        last_rise = $time;
        if (nbits < 8)
        begin
            sh = {sh[6:0], i_sda};
            nbits++;
            if (nbits == 8)
                rx_q.push_back(sh);
        end
        else
            nbits = 0;
    end

    // The acknowledge is held low through the ninth slot unless told to refuse.
    always @(negedge i_scl)
        o_sda_oe <= (nbits == 8) && (rx_q.size() - 1 != int'(i_nack_at));

    // A slow slave keeps the clock low for a while after each falling edge.
    always @(negedge i_scl)
        if (i_stretch)
        begin
            o_scl_oe = 1'b1;
            #2000;
            o_scl_oe = 1'b0;
        end
endmodule

// [i2c_write_engine.sv]
// Two-wire bus master write engine with APB registers and an interrupt.
// Assumes pull-ups on the port pins; the pins are synchronised inside.
//
// Function
// RULE_01 - Control byte: seven address bits, direction bit zero
// RULE_02 - Direction bit always sent as zero
// RULE_03 - Control byte, then address, then data
// RULE_04 - Optional 8/16-bit address, high byte first
// RULE_05 - Word items two bytes, byte items one
// RULE_06 - Items sent in order, each own width
// RULE_07 - Single mode: one byte, no start/stop, report acknowledge
// RULE_08 - Acknowledge zero, not-acknowledge one, flag and shadow
// RULE_09 - Array bytes ascending, limited by optional count
// RULE_10 - Data line defaults to port pin 0
// RULE_11 - Clock line defaults to port pin 1
// RULE_12 - Pin choice fixed at elaboration
// RULE_13 - Slow option keeps bus at 100 kHz
// RULE_14 - Pins open drain: released or driven low
// RULE_15 - Host wraps single bytes with bus primitives
// RULE_16 - Full form adds start before, stop after
`timescale 1ns/1ns
module i2c_write_engine
    import i2cw_pkg::*;
#(
    parameter int SDA_PIN = SDA_PIN_DEFAULT,
    parameter int SCL_PIN = SCL_PIN_DEFAULT
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire apb_req_s i_apb,
    output apb_rsp_s o_apb,
    input wire logic [PORT_W-1:0] i_porta_in,
    output logic [PORT_W-1:0] o_porta_out,
    output logic [PORT_W-1:0] o_porta_oe,
    output logic o_irq
);
    state_s r_q;
    state_s r_d;
    logic sda_in;
    logic scl_in;
    logic tick;
    logic step;
    logic slow_eff;
    logic [3:0] limit;
    seg_e succ_seg;
    logic [3:0] succ_idx;
    logic succ_end;
    logic [7:0] succ_byte;
    logic [16:0] succ_item;
    logic [1:0] ev;
    logic acc;
    logic [31:0] rd;
    logic err;

    assign o_apb = r_q.apb;
    assign o_porta_oe = r_q.oe;
    assign o_porta_out = r_q.drive;
    assign o_irq = r_q.irq;

    always_comb
    begin
        r_d = r_q;
        ev = 2'h0;
        rd = 32'h0;
        err = 1'b0;
        r_d.sync1 = i_porta_in;
        r_d.sync2 = r_q.sync1;
        r_d.drive = DRIVE_LEVEL; // RULE_14
        sda_in = r_q.sync2[SDA_PIN]; // RULE_10 RULE_12
        scl_in = r_q.sync2[SCL_PIN]; // RULE_11 RULE_12
        slow_eff = r_q.slow && SLOW_NEEDED; // RULE_13
        tick = (r_q.st != ST_IDLE) && (r_q.div_cnt == 8'h0);
        // A slave holding the clock low stretches the high quarter.
        step = tick && !(r_q.qtr == 2'h3 && !scl_in
            && (r_q.st == ST_BIT || r_q.st == ST_ACK || r_q.st == ST_STOP));
        if (r_q.st != ST_IDLE)
        begin
            if (tick)
            begin
                r_d.div_cnt = (slow_eff ? SLOW_QTR_CYC : FAST_QTR_CYC) - 8'h1; // RULE_13
            end
            else
            begin
                r_d.div_cnt = r_q.div_cnt - 8'h1;
            end
        end
        limit = (r_q.send_all || r_q.count > ITEM_LIMIT) ? ITEM_LIMIT : r_q.count; // RULE_09
        succ_idx = r_q.idx;
        succ_seg = SEG_DLO;
        succ_end = 1'b0;
        case (r_q.seg)
            SEG_CTRL:
            begin
                succ_idx = 4'h0;
                succ_seg = (r_q.amode == AMODE_16) ? SEG_AHI : SEG_DLO; // RULE_03 RULE_04
            end
            SEG_AHI:
            begin
                succ_seg = SEG_ALO; // RULE_04
            end
            SEG_ALO:
            begin
                succ_idx = 4'h0;
            end
            SEG_DHI:
            begin
                succ_seg = SEG_DLO; // RULE_05
            end
            default:
            begin
                succ_idx = r_q.idx + 4'h1; // RULE_06 RULE_09
            end
        endcase
        succ_item = r_q.items[succ_idx[2:0]];
        if (succ_seg == SEG_DLO && r_q.seg != SEG_DHI)
        begin
            if (r_q.seg == SEG_CTRL && r_q.amode == AMODE_8)
            begin
                succ_seg = SEG_ALO;
            end
            else if (succ_idx >= limit)
            begin
                succ_end = 1'b1;
            end
            else if (succ_item[ITEM_WORD_BIT])
            begin
                succ_seg = SEG_DHI; // RULE_05
            end
        end
        case (succ_seg)
            SEG_AHI: succ_byte = r_q.addr[15:8];
            SEG_ALO: succ_byte = r_q.addr[7:0];
            SEG_DHI: succ_byte = succ_item[15:8];
            default: succ_byte = succ_item[7:0];
        endcase

        if (step)
        begin
            r_d.qtr = r_q.qtr + 2'h1;
            case (r_q.st)
                ST_START:
                begin
                    case (r_q.qtr)
                        2'h0:
                        begin
                            r_d.oe[SDA_PIN] = 1'b0;
                            r_d.oe[SCL_PIN] = 1'b0;
                        end
                        2'h2: r_d.oe[SDA_PIN] = 1'b1; // RULE_16
                        2'h3:
                        begin
                            r_d.oe[SCL_PIN] = 1'b1;
                            r_d.shift = {r_q.ctrl_byte[7:1], 1'b0}; // RULE_01 RULE_02
                            r_d.seg = SEG_CTRL; // RULE_03
                            r_d.st = ST_BIT;
                        end
                        default: r_d.st = ST_START;
                    endcase
                end
                ST_BIT:
                begin
                    // Data moves a quarter after the clock falls, never while it is high.
                    case (r_q.qtr)
                        2'h0: r_d.oe[SCL_PIN] = 1'b1; // RULE_14
                        2'h1: r_d.oe[SDA_PIN] = ~r_q.shift[7];
                        2'h2: r_d.oe[SCL_PIN] = 1'b0;
                        2'h3:
                        begin
                            r_d.shift = {r_q.shift[6:0], 1'b0};
                            r_d.bit_cnt = r_q.bit_cnt + 3'h1;
                            if (r_q.bit_cnt == 3'h7)
                            begin
                                r_d.st = ST_ACK;
                            end
                        end
                        default: r_d.st = ST_BIT;
                    endcase
                end
                ST_ACK:
                begin
                    case (r_q.qtr)
                        2'h0: r_d.oe[SCL_PIN] = 1'b1;
                        2'h1: r_d.oe[SDA_PIN] = 1'b0;
                        2'h2: r_d.oe[SCL_PIN] = 1'b0;
                        2'h3:
                        begin
                            r_d.ack_flag = sda_in; // RULE_08
                            r_d.ack_shadow = sda_in; // RULE_08
                            ev[IRQ_NACK_BIT] = sda_in;
                            if (r_q.single)
                            begin
                                r_d.st = ST_DONE; // RULE_07
                            end
                            else if (sda_in || succ_end)
                            begin
                                r_d.st = ST_STOP;
                            end
                            else
                            begin
                                r_d.seg = succ_seg;
                                r_d.idx = succ_idx;
                                r_d.shift = succ_byte;
                                r_d.st = ST_BIT;
                            end
                        end
                        default: r_d.st = ST_ACK;
                    endcase
                end
                ST_STOP:
                begin
                    case (r_q.qtr)
                        2'h0: r_d.oe[SCL_PIN] = 1'b1;
                        2'h1: r_d.oe[SDA_PIN] = 1'b1;
                        2'h2: r_d.oe[SCL_PIN] = 1'b0;
                        2'h3:
                        begin
                            r_d.oe[SDA_PIN] = 1'b0; // RULE_16
                            r_d.st = ST_DONE;
                        end
                        default: r_d.st = ST_STOP;
                    endcase
                end
                default: r_d.st = r_q.st;
            endcase
        end
        if (r_q.st == ST_DONE)
        begin
            ev[IRQ_DONE_BIT] = 1'b1;
            r_d.st = ST_IDLE;
        end

        acc = i_apb.psel && i_apb.penable;
        r_d.apb.pready = acc && !r_q.apb.pready;
        r_d.apb.pslverr = 1'b0;
        r_d.apb.prdata = 32'h0;
        if (i_apb.paddr[1:0] != 2'h0)
        begin
            err = 1'b1;
        end
        else if (i_apb.paddr[7:5] == ITEM_PAGE)
        begin
            rd = 32'(r_q.items[i_apb.paddr[4:2]]);
        end
        else
        begin
            case (i_apb.paddr)
                OFF_CTRL: rd = 32'({r_q.send_all, r_q.slow, r_q.amode, r_q.single, 1'b0});
                OFF_TARGET: rd = 32'({r_q.addr, r_q.ctrl_byte});
                OFF_COUNT: rd = 32'(r_q.count);
                OFF_STATUS: rd = 32'({r_q.ack_shadow, r_q.ack_flag, r_q.st != ST_IDLE});
                OFF_IRQ_STAT: rd = 32'(r_q.irq_stat);
                OFF_IRQ_MASK: rd = 32'(r_q.irq_mask);
                default: err = 1'b1;
            endcase
        end
        if (acc && !r_q.apb.pready)
        begin
            r_d.apb.prdata = rd;
            r_d.apb.pslverr = err;
        end
        // Writes land on the edge where the master sees pready high.
        if (acc && r_q.apb.pready && i_apb.pwrite && !r_q.apb.pslverr)
        begin
            if (i_apb.paddr[7:5] == ITEM_PAGE)
            begin
                r_d.items[i_apb.paddr[4:2]] = i_apb.pwdata[16:0];
            end
            else if (i_apb.paddr == OFF_CTRL && r_q.st == ST_IDLE)
            begin
                r_d.single = i_apb.pwdata[CTRL_SINGLE_BIT];
                r_d.amode = i_apb.pwdata[CTRL_AMODE_LSB +: 2];
                r_d.slow = i_apb.pwdata[CTRL_SLOW_BIT];
                r_d.send_all = i_apb.pwdata[CTRL_ALL_BIT];
                if (i_apb.pwdata[CTRL_GO_BIT])
                begin
                    r_d.qtr = 2'h0;
                    r_d.div_cnt = 8'h0;
                    r_d.bit_cnt = 3'h0;
                    r_d.seg = SEG_DLO;
                    r_d.idx = 4'h0;
                    r_d.shift = r_q.items[0][7:0];
                    r_d.st = i_apb.pwdata[CTRL_SINGLE_BIT] ? ST_BIT : ST_START; // RULE_07 RULE_16
                end
            end
            else if (i_apb.paddr == OFF_TARGET)
            begin
                r_d.ctrl_byte = i_apb.pwdata[7:0];
                r_d.addr = i_apb.pwdata[TGT_ADDR_LSB +: 16];
            end
            else if (i_apb.paddr == OFF_COUNT)
            begin
                r_d.count = i_apb.pwdata[3:0];
            end
            else if (i_apb.paddr == OFF_IRQ_STAT)
            begin
                r_d.irq_stat = r_q.irq_stat & ~i_apb.pwdata[1:0];
            end
            else if (i_apb.paddr == OFF_IRQ_MASK)
            begin
                r_d.irq_mask = i_apb.pwdata[1:0];
            end
        end
        // New events win over a clear in the same cycle.
        r_d.irq_stat = r_d.irq_stat | ev;
        r_d.irq = |(r_d.irq_stat & r_d.irq_mask);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            r_q <= STATE_RESET;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    dir_bit_zero_a: assert property ((step && r_q.st == ST_BIT && r_q.seg == SEG_CTRL // RULE_02
        && r_q.bit_cnt == 3'h7 && r_q.qtr == 2'h1) |=> r_q.oe[SDA_PIN])
        else $error("direction bit not sent as zero");
    start_edge_a: assert property ((step && r_q.st == ST_START && r_q.qtr == 2'h2) // RULE_16
        |=> r_q.oe[SDA_PIN] && !r_q.oe[SCL_PIN])
        else $error("start condition not formed with clock high");
    stop_edge_a: assert property ((step && r_q.st == ST_STOP && r_q.qtr == 2'h3) // RULE_16
        |=> !r_q.oe[SDA_PIN] && !r_q.oe[SCL_PIN] ##1 r_q.st == ST_IDLE)
        else $error("stop condition did not release both lines");
    single_nostart_a: assert property ((r_q.st == ST_IDLE && r_d.st != ST_IDLE && r_d.single) // RULE_07
        |=> r_q.st == ST_BIT)
        else $error("single mode began with a start condition");
    ack_report_a: assert property ((step && r_q.st == ST_ACK && r_q.qtr == 2'h3) // RULE_08
        |=> r_q.ack_flag == $past(sda_in) && r_q.ack_shadow == r_q.ack_flag)
        else $error("acknowledge status not reported");
    addr_order_a: assert property ((step && r_q.st == ST_ACK && r_q.qtr == 2'h3 // RULE_04
        && r_q.seg == SEG_AHI && !sda_in && !r_q.single) |=> r_q.seg == SEG_ALO)
        else $error("address low byte did not follow high byte");
    word_pair_a: assert property ((step && r_q.st == ST_ACK && r_q.qtr == 2'h3 // RULE_05
        && r_q.seg == SEG_DHI && !sda_in && !r_q.single) |=> r_q.seg == SEG_DLO)
        else $error("word item not sent as two bytes");
    item_order_a: assert property ((step && r_q.st == ST_ACK && r_q.qtr == 2'h3 // RULE_09
        && r_q.seg == SEG_DLO && !sda_in && !r_q.single && !succ_end)
        |=> r_q.idx == $past(r_q.idx) + 4'h1)
        else $error("items not sent in ascending order");
    open_drain_a: assert property (o_porta_out == DRIVE_LEVEL // RULE_14
        && (o_porta_oe & ~((8'h1 << SDA_PIN) | (8'h1 << SCL_PIN))) == 8'h0)
        else $error("pin driven high or wrong pin driven");
    slow_rate_a: assert property ((tick && r_q.slow && r_q.st != ST_IDLE) // RULE_13
        |=> r_q.div_cnt == SLOW_QTR_CYC - 8'h1)
        else $error("slow bus quarter period wrong");
endmodule

// [i2cw_pkg.sv]
// Constants, enumerations and carrier structs of the two-wire write engine.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
package i2cw_pkg;
    localparam int PORT_W = 8;
    localparam int SDA_PIN_DEFAULT = 0;
    localparam int SCL_PIN_DEFAULT = 1;
    localparam int NUM_ITEMS = 8;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TARGET = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [2:0] ITEM_PAGE = 3'h1;

    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_SINGLE_BIT = 1;
    localparam int CTRL_AMODE_LSB = 2;
    localparam int CTRL_SLOW_BIT = 4;
    localparam int CTRL_ALL_BIT = 5;
    localparam int TGT_ADDR_LSB = 8;
    localparam int ITEM_WORD_BIT = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ACK_BIT = 1;
    localparam int STAT_SHADOW_BIT = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_NACK_BIT = 1;

    localparam logic [1:0] AMODE_8 = 2'h1;
    localparam logic [1:0] AMODE_16 = 2'h2;
    localparam logic [3:0] ITEM_LIMIT = 4'h8;
    localparam logic [7:0] DRIVE_LEVEL = 8'h00;

    localparam int SYS_CLK_HZ = 20000000;
    localparam int SLOW_THRESHOLD_HZ = 4000000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int FAST_QTR_NS = 625;
    localparam int SLOW_QTR_NS = 2500;
    localparam logic [7:0] FAST_QTR_CYC = 8'((FAST_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SLOW_QTR_CYC = 8'((SLOW_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam bit SLOW_NEEDED = SYS_CLK_HZ > SLOW_THRESHOLD_HZ;

    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_STOP, ST_DONE} state_e;
    typedef enum logic [2:0] {SEG_CTRL, SEG_AHI, SEG_ALO, SEG_DHI, SEG_DLO} seg_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        state_e st;
        seg_e seg;
        logic [3:0] idx;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [1:0] qtr;
        logic [7:0] div_cnt;
        logic [7:0] oe;
        logic [7:0] drive;
        logic ack_flag;
        logic ack_shadow;
        logic single;
        logic [1:0] amode;
        logic slow;
        logic send_all;
        logic [7:0] ctrl_byte;
        logic [15:0] addr;
        logic [3:0] count;
        logic [7:0][16:0] items;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        apb_rsp_s apb;
    } state_s;

    localparam state_s STATE_RESET = '{st: ST_IDLE, seg: SEG_CTRL, default: '0};
endpackage

// [tb_i2c_write_engine.sv]
// Self-checking bench for the two-wire write engine.
// Assumes pull-ups on both bus lines and the slave model on the default pins.
`timescale 1ns/1ns
module tb_i2c_write_engine
    import i2cw_pkg::*;
;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    apb_req_s req = '0;
    apb_rsp_s rsp;
    logic [7:0] porta_out;
    logic [7:0] porta_oe;
    logic [7:0] pins;
    logic irq;
    logic sda_oe;
    logic scl_oe;
    logic [7:0] nack_at = 8'hff;
    logic stretch = 1'b0;
    logic pin_bad = 1'b0;
    int err_total = 0;
    int checks_done = 0;
    logic [7:0] exp_q[$];
    wire scl = ~(porta_oe[SCL_PIN_DEFAULT] | scl_oe);
    wire sda = ~(porta_oe[SDA_PIN_DEFAULT] | sda_oe);
    assign pins = {6'h3f, scl, sda};

    always #25 i_ref_clk = ~i_ref_clk;

    i2c_write_engine DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_apb(req), .o_apb(rsp),
        .i_porta_in(pins), .o_porta_out(porta_out), .o_porta_oe(porta_oe), .o_irq(irq));

    i2c_slave_model partner (.i_scl(scl), .i_sda(sda), .i_nack_at(nack_at),
        .i_stretch(stretch), .o_sda_oe(sda_oe), .o_scl_oe(scl_oe));

    always @(posedge i_ref_clk)
        if (!i_rst && (porta_out !== 8'h00 || porta_oe[7:2] !== 6'h00))
            pin_bad <= 1'b1;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge i_ref_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge i_ref_clk);
        req.penable <= 1'b1;
        n = 0;
        // The answer is taken at the rising edge that shows pready high.
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1)
        begin
            err_total++;
            complete_run();
        end
        r = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(what, r, exp);
    endtask

    // Starts a transfer and polls the busy flag until it clears.
    task automatic run(input logic [31:0] ctrl);
        logic [31:0] r;
        logic e;
        int n;
        partner.rx_q.delete();
        partner.starts = 0;
        partner.stops = 0;
        wr(OFF_CTRL, ctrl);
        n = 0;
        do
        begin
            apb(1'b0, OFF_STATUS, 32'h0, r, e);
            n++;
        end
        while (r[STAT_BUSY_BIT] !== 1'b0 && n < 5000);
        if (n >= 5000)
        begin
            err_total++;
            complete_run();
        end
    endtask

    task automatic check_bytes(input int n_start, input int n_stop);
        check("byte count", 32'(partner.rx_q.size()), 32'(exp_q.size()));
        foreach (exp_q[i])
            if (i < partner.rx_q.size())
                check("bus byte", {24'h0, partner.rx_q[i]}, {24'h0, exp_q[i]});
        check("start count", 32'(partner.starts), 32'(n_start));
        check("stop count", 32'(partner.stops), 32'(n_stop));
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd_chk("status at reset", OFF_STATUS, 32'h0);
        rd_chk("irq status at reset", OFF_IRQ_STAT, 32'h0);
        check("irq at reset", {31'h0, irq}, 32'h0);
        apb(1'b0, 8'h18, 32'h0, r, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        check("unmapped data", r, 32'h0);
    endtask

    task automatic t_full();
        wr(OFF_TARGET, {8'h00, 16'h1234, 8'ha1});
        wr(OFF_COUNT, 32'h3);
        wr(8'h20, 32'h1abcd);
        wr(8'h24, 32'h0f042);
        wr(8'h28, 32'h10099);
        wr(OFF_IRQ_MASK, 32'h1);
        run(32'h9);
        exp_q = '{8'ha0, 8'h12, 8'h34, 8'hab, 8'hcd, 8'h42, 8'h00, 8'h99};
        check_bytes(1, 1);
        rd_chk("status ack", OFF_STATUS, 32'h0);
        rd_chk("irq done", OFF_IRQ_STAT, 32'h1);
        check("irq raised", {31'h0, irq}, 32'h1);
        wr(OFF_IRQ_STAT, 32'h1);
        rd_chk("irq cleared", OFF_IRQ_STAT, 32'h0);
        check("irq dropped", {31'h0, irq}, 32'h0);
    endtask

    task automatic t_array();
        for (int i = 0; i < 8; i++)
            wr(8'(8'h20 + 4 * i), 32'(8'h30 + i));
        wr(OFF_TARGET, {8'h00, 16'h0077, 8'ha0});
        wr(OFF_COUNT, 32'h2);
        wr(OFF_IRQ_MASK, 32'h2);
        stretch <= 1'b1;
        run(32'h25);
        stretch <= 1'b0;
        exp_q = '{8'ha0, 8'h77, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37};
        check_bytes(1, 1);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(OFF_IRQ_STAT, 32'h3);
        run(32'h1);
        exp_q = '{8'ha0, 8'h30, 8'h31};
        check_bytes(1, 1);
    endtask

    task automatic t_nack();
        wr(OFF_TARGET, {8'h00, 16'h1234, 8'ha0});
        nack_at <= 8'h01;
        run(32'h9);
        exp_q = '{8'ha0, 8'h12};
        check_bytes(1, 1);
        rd_chk("status nack", OFF_STATUS, 32'h6);
        rd_chk("irq nack", OFF_IRQ_STAT, 32'h3);
        check("irq nack raised", {31'h0, irq}, 32'h1);
        wr(OFF_IRQ_STAT, 32'h3);
    endtask

    task automatic t_single();
        wr(OFF_IRQ_MASK, 32'h0);
        wr(8'h20, 32'h1015a);
        nack_at <= 8'hff;
        run(32'h3);
        exp_q = '{8'h5a};
        check_bytes(0, 0);
        rd_chk("single ack", OFF_STATUS, 32'h0);
        check("fast bit time", 32'(partner.period), 32'(FAST_QTR_CYC) * 4 * CLK_PERIOD_NS);
        nack_at <= 8'h00;
        run(32'h3);
        rd_chk("single nack", OFF_STATUS, 32'h6);
        nack_at <= 8'hff;
        run(32'h13);
        check("slow bit time", 32'(partner.period), 32'h2710);
    endtask

    initial
    begin
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        t_reset();
        t_full();
        t_array();
        t_nack();
        t_single();
        check("pin use", {31'h0, pin_bad}, 32'h0);
        complete_run();
    end
endmodule
